// File: rtl/dtdc_pkg.sv
/*
 data tenure delay control package: widths, beat counts and state codes
 assumes a single bus clock; no software-visible registers
*/
package dtdc_pkg;
   localparam int unsigned DTDC_DATA_W = 64;
   localparam int unsigned DTDC_BEATS_W = 3;
   localparam logic [2:0] DTDC_BURST_BEATS = 3'h4;
   localparam logic [2:0] DTDC_SINGLE_BEATS = 3'h1;
   localparam logic [2:0] DTDC_BEAT_RESET = 3'h0;
   localparam logic [1:0] DTDC_DEPTH_RESET = 2'h0;
   localparam int unsigned DTDC_QUEUE_DEPTH = 2;
   localparam logic DTDC_FLAG_RESET = 1'b0;

   // gray codes along idle -> wait grant -> data -> retry window
   typedef enum logic [1:0] {
      DTDC_IDLE = 2'b00,
      DTDC_WAIT_GRANT = 2'b01,
      DTDC_DATA = 2'b11,
      DTDC_HOLD_RETRY = 2'b10
   } dtdc_state_t;
endpackage

// File: rtl/dtdc_req_if.sv
/*
 interface carrying one pending data tenure request between the top and the queue
 assumes both ends on clk_sys
*/
`timescale 1ns/1ns
`default_nettype none
interface dtdc_req_if;
   logic push;
   logic pop;
   logic wr;
   logic burst;
   logic [1:0] depth;
   logic head_wr;
   logic head_burst;
   logic head_valid;
   modport owner (output push, output pop, output wr, output burst,
      input depth, input head_wr, input head_burst, input head_valid);
   modport queue (input push, input pop, input wr, input burst,
      output depth, output head_wr, output head_burst, output head_valid);
endinterface
`default_nettype wire

// File: rtl/dtdc_pend_queue.sv
/*
 small queue of address tenures whose data tenures are still outstanding
 assumes push is only issued while depth is below the queue depth
*/
`timescale 1ns/1ns
`default_nettype none
module dtdc_pend_queue
   import dtdc_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // request port
   dtdc_req_if.queue req
);
   logic [1:0] kind_ff [DTDC_QUEUE_DEPTH];
   logic [1:0] nxt_kind [DTDC_QUEUE_DEPTH];
   logic [1:0] depth_ff;
   logic [1:0] nxt_depth;

   // shift-out queue: entry 0 is always the oldest
   always_comb begin
      nxt_kind = kind_ff;
      nxt_depth = depth_ff;
      if (req.pop && depth_ff != 2'h0) begin
         nxt_kind[0] = kind_ff[1];
         nxt_depth = depth_ff - 2'h1;
      end
      if (req.push) begin
         nxt_kind[nxt_depth[0]] = {req.wr, req.burst};
         nxt_depth = nxt_depth + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         depth_ff <= DTDC_DEPTH_RESET;
         kind_ff[0] <= 2'h0;
         kind_ff[1] <= 2'h0;
      end else begin
         depth_ff <= nxt_depth;
         kind_ff <= nxt_kind;
      end
   end

   assign req.depth = depth_ff;
   assign req.head_valid = depth_ff != 2'h0;
   assign req.head_wr = kind_ff[0][1];
   assign req.head_burst = kind_ff[0][0];
endmodule
`default_nettype wire

// File: rtl/dtdc_core.sv
/*
 processor-side data tenure pacing and termination: waits for the data bus
 grant, drives write data until each beat is acknowledged, counts beats,
 honours beat retry on reads only, aborts on error acknowledge and flags an
 exception. assumes all bus inputs synchronous to clk_sys, and that the
 address side issues tenures through addr_start only when addr_ready is high.
*/
// Operation
// - beat_retry is honoured only on read tenures and ignored on writes.
// - bidirectional data lines are driven only while this master owns a write tenure.
// - error_ack raises an exception later instead of retrying the transfer.
// - later address tenures are held off while the pending queue is full.
// - while beat_retry is asserted on a read tenure this master keeps the data bus, unless error_ack aborts the tenure.
`timescale 1ns/1ns
`default_nettype none
module dtdc_core
   import dtdc_pkg::*;
#(
   parameter int unsigned DATA_W = DTDC_DATA_W
)(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // address side of the core
   input wire logic addr_start,
   input wire logic addr_wr,
   input wire logic addr_burst,
   output logic addr_ready,
   // write data source, one word per beat
   input wire logic [DATA_W-1:0] wr_data,
   output logic wr_data_take,
   // read data sink
   output logic [DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic rd_discard,
   // tenure status
   output logic tenure_done,
   output logic error_exception,
   // bus control from arbiter and slave
   input wire logic dbus_grant,
   input wire logic beat_ack,
   input wire logic beat_retry,
   input wire logic error_ack,
   // bus data busy, open drain style
   input wire logic dbus_busy_in,
   output logic dbus_busy_out,
   output logic dbus_busy_oe,
   // bidirectional data lines
   input wire logic [DATA_W-1:0] dbus_in,
   output logic [DATA_W-1:0] dbus_out,
   output logic dbus_oe
);
   // pending address tenures; the head leaves the queue only when its data tenure starts
   dtdc_req_if req ();
   dtdc_pend_queue u_queue (
      .clk_sys(clk_sys),
      .reset(reset),
      .req(req)
   );

   // tenure state; beats_ff counts acknowledged beats that no retry has taken back
   dtdc_state_t state_ff, nxt_state;
   logic [2:0] beats_ff, nxt_beats;
   logic wr_ff, nxt_wr;
   logic burst_ff, nxt_burst;
   logic acked_ff, nxt_acked;
   logic exc_ff, nxt_exc;
   logic [DATA_W-1:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff, nxt_rd_valid;
   logic [DATA_W-1:0] wdata_ff, nxt_wdata;
   logic done_pulse;
   logic take;

   // beats a tenure needs before it ends
   function automatic logic [2:0] beats_needed(input logic burst);
      return burst ? DTDC_BURST_BEATS : DTDC_SINGLE_BEATS;
   endfunction

   // address tenures are held off when the pending queue is full
   assign addr_ready = req.depth < 2'(DTDC_QUEUE_DEPTH);
   assign req.push = addr_start && addr_ready;
   assign req.wr = addr_wr;
   assign req.burst = addr_burst;

   // tenure state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_beats = beats_ff;
      nxt_wr = wr_ff;
      nxt_burst = burst_ff;
      nxt_acked = 1'b0;
      nxt_exc = exc_ff;
      nxt_rd_data = rd_data_ff;
      nxt_rd_valid = 1'b0;
      nxt_wdata = wdata_ff;
      done_pulse = 1'b0;
      take = 1'b0;
      req.pop = 1'b0;
      rd_discard = 1'b0;
      unique case (state_ff)
         DTDC_IDLE: begin
            if (req.head_valid) begin
               // latch the head's kind now; the entry itself stays queued until grant
               nxt_state = DTDC_WAIT_GRANT;
               nxt_wr = req.head_wr;
               nxt_burst = req.head_burst;
               nxt_beats = DTDC_BEAT_RESET;
            end
         end
         DTDC_WAIT_GRANT: begin
            // stay put however long arbitration holds the grant off
            if (dbus_grant && !dbus_busy_in) begin
               nxt_state = DTDC_DATA;
               // popping only here keeps addr_ready honest about tenures still waiting
               req.pop = 1'b1;
               if (wr_ff) begin
                  nxt_wdata = wr_data; // first write beat loaded
                  take = 1'b1;
               end
            end
         end
         DTDC_DATA, DTDC_HOLD_RETRY: begin
            if (error_ack) begin
               // abort the tenure; later ack and retry belong to nobody
               nxt_state = DTDC_IDLE;
               nxt_exc = 1'b1;
               // a beat_retry that would have landed on this tenure is dropped too
               done_pulse = 1'b1;
            end else if (!wr_ff && acked_ff && beat_retry) begin
               // previous read beat invalid; count it back, hold the bus
               rd_discard = 1'b1;
               nxt_beats = beats_ff - 3'h1;
               nxt_state = DTDC_DATA;
               if (beat_ack) begin
                  // replacement beat rides on the first retry cycle: it takes the
                  // discarded beat's place and is itself open to a later retry
                  nxt_beats = beats_ff;
                  nxt_acked = 1'b1;
                  nxt_rd_data = dbus_in;
                  nxt_rd_valid = 1'b1;
                  if (beats_ff == beats_needed(burst_ff)) begin
                     nxt_state = DTDC_HOLD_RETRY;
                  end
               end
            end else if (state_ff == DTDC_HOLD_RETRY && !beat_ack) begin
               // retry window closed with no retry: tenure really over
               nxt_state = DTDC_IDLE;
               done_pulse = 1'b1;
            end else if (beat_ack) begin
               // wait states are simply cycles without beat_ack
               nxt_beats = beats_ff + 3'h1;
               nxt_acked = 1'b1;
               if (!wr_ff) begin
                  nxt_rd_data = dbus_in;
                  nxt_rd_valid = 1'b1;
               end
               if (nxt_beats == beats_needed(burst_ff)) begin
                  // writes ignore beat_retry entirely, so they end here
                  nxt_state = wr_ff ? DTDC_IDLE : DTDC_HOLD_RETRY;
                  done_pulse = wr_ff;
               end else if (wr_ff) begin
                  nxt_wdata = wr_data; // next beat only after ack
                  take = 1'b1;
               end
            end
         end
      endcase
   end

   // register stage of the tenure state machine
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_ff <= DTDC_IDLE;
         beats_ff <= DTDC_BEAT_RESET;
         wr_ff <= DTDC_FLAG_RESET;
         burst_ff <= DTDC_FLAG_RESET;
         acked_ff <= DTDC_FLAG_RESET;
         exc_ff <= DTDC_FLAG_RESET;
         rd_data_ff <= '0;
         rd_valid_ff <= DTDC_FLAG_RESET;
         wdata_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         beats_ff <= nxt_beats;
         wr_ff <= nxt_wr;
         burst_ff <= nxt_burst;
         acked_ff <= nxt_acked;
         exc_ff <= nxt_exc;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
         wdata_ff <= nxt_wdata;
      end
   end

   // busy held through the retry window so no other master can start
   assign dbus_busy_oe = state_ff == DTDC_DATA || state_ff == DTDC_HOLD_RETRY;
   // the busy wire is active low: enabling the driver is what asserts busy
   assign dbus_busy_out = 1'b0;
   // data lines driven only in our own write tenure, held until ack
   assign dbus_oe = wr_ff && state_ff == DTDC_DATA;
   assign dbus_out = wdata_ff;
   assign wr_data_take = take;
   // read data hold until the next read beat; rd_valid marks the cycle they are new
   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;
   assign tenure_done = done_pulse;
   // sticky until reset: the exception logic takes it when convenient
   // no clear here, since the failed access itself is not recorded anywhere
   assign error_exception = exc_ff;
endmodule
`default_nettype wire

// File: tb/dtdc_chk.sv
/*
 concurrent checks on the ports of dtdc_core
 assumes one clock domain and a synchronous active high reset
*/
`timescale 1ns/1ns
`default_nettype none
module dtdc_chk #(
   parameter int unsigned DATA_W = 64
)(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // bus side
   input wire logic dbus_grant,
   input wire logic beat_ack,
   input wire logic beat_retry,
   input wire logic error_ack,
   input wire logic dbus_busy_oe,
   input wire logic dbus_oe,
   input wire logic [DATA_W-1:0] dbus_out,
   // user side
   input wire logic wr_data_take,
   input wire logic rd_valid,
   input wire logic rd_discard,
   input wire logic tenure_done,
   input wire logic error_exception
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // data lines only while this master owns the data bus
   a_oe_in_tenure: assert property (dbus_oe |-> dbus_busy_oe)
      else $error("data lines driven outside a tenure");
   a_start_grant: assert property ($rose(dbus_busy_oe) |-> $past(dbus_grant))
      else $error("data tenure began without grant");
   a_write_hold: assert property (dbus_oe && !beat_ack && !error_ack |=> dbus_oe && $stable(dbus_out))
      else $error("stalled write beat changed");
   a_take_on_ack: assert property (dbus_oe && beat_ack && !tenure_done |-> wr_data_take)
      else $error("acked write beat did not fetch next word");
   a_read_wait: assert property (beat_ack && dbus_busy_oe && !dbus_oe |=> rd_valid)
      else $error("read ack gave no data");
   a_wr_no_retry: assert property (dbus_oe |-> !rd_discard)
      else $error("beat retry honoured on a write");
   a_retry_flush: assert property (beat_retry && $past(beat_ack) && dbus_busy_oe && !dbus_oe |-> rd_discard)
      else $error("read beat retry not flushed");
   a_err_abort: assert property (error_ack && dbus_busy_oe |-> tenure_done ##1 !dbus_busy_oe)
      else $error("error ack did not end the tenure");
   a_exc_raise: assert property (error_ack && dbus_busy_oe |-> ##[1:4] error_exception)
      else $error("no exception after error ack");
   // sticky flag: a slip that clears it shows here
   a_exc_sticky: assert property (error_exception |=> error_exception)
      else $error("exception flag dropped");
   c_retry: cover property (rd_discard);
   c_err: cover property (error_ack && dbus_busy_oe);
   c_wr_stall: cover property (dbus_oe && !beat_ack);
endmodule
bind dtdc_core dtdc_chk #(.DATA_W(DATA_W)) u_chk (.clk_sys, .reset, .dbus_grant, .beat_ack,
   .beat_retry, .error_ack, .dbus_busy_oe, .dbus_oe, .dbus_out, .wr_data_take, .rd_valid,
   .rd_discard, .tenure_done, .error_exception);
`default_nettype wire

// File: tb/dtdc_slave_model.sv
/*
 arbiter and slave model: grants, paces beats, retries and errors on command
 assumes the bench sets the commands before each tenure and feeds random bits
*/
`timescale 1ns/1ns
`default_nettype none
module dtdc_slave_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // commands and pacing bits from the bench
   input wire logic [7:0] rnd,
   input wire logic m_rd,
   input wire logic [2:0] m_n,
   input wire logic [2:0] m_retry,
   input wire logic [2:0] m_err,
   // processor side
   input wire logic dbus_busy_oe,
   output logic dbus_grant,
   output logic beat_ack,
   output logic beat_retry,
   output logic error_ack,
   output logic [63:0] dbus_in
);
   logic [2:0] acked;
   logic rt_done;
   logic rep_now;
   // a replacement beat may ride on the first retry cycle; writes never pass the count
   assign rep_now = rnd[2] && (m_rd || acked < m_n);
   // one event per clock bar a retry with its replacement; retry is one-shot per tenure
   always_ff @(posedge clk_sys) begin
      beat_ack <= 1'b0;
      beat_retry <= 1'b0;
      error_ack <= 1'b0;
      dbus_grant <= rnd[0] | rnd[1];
      dbus_in <= ~dbus_in; // released lines wander, never hold
      if (reset) begin
         dbus_in <= 64'h0;
      end
      if (reset || !dbus_busy_oe) begin
         acked <= 3'h0;
         rt_done <= 1'b0;
      end else if (beat_ack && !rt_done && acked == m_retry) begin
         beat_retry <= 1'b1;
         rt_done <= 1'b1;
         beat_ack <= rep_now;
         acked <= (m_rd ? acked - 3'h1 : acked) + {2'h0, rep_now};
         dbus_in <= {56'h0, 5'h14, acked - 3'h1};
      end else if (beat_retry && !beat_ack) begin
         // retry stays up until the cycle after the replacement beat
         beat_retry <= 1'b1;
         if (acked < m_n && rnd[2]) begin
            beat_ack <= 1'b1;
            acked <= acked + 3'h1;
            dbus_in <= {56'h0, 5'h14, acked};
         end
      end else if (beat_retry || error_ack) begin
         acked <= acked; // quiet cycle
      end else if (m_err != 3'h0 && acked == m_err - 3'h1) begin
         error_ack <= 1'b1;
      end else if (acked < m_n && rnd[2]) begin
         beat_ack <= 1'b1;
         acked <= acked + 3'h1;
         dbus_in <= {56'h0, 5'h14, acked};
      end
   end
endmodule
`default_nettype wire

// File: tb/data_tenure_delay_control_tb.sv
/*
 self-checking bench for dtdc_core with the slave model
 assumes tenures issued one at a time, busy wire seen only from this master
*/
`timescale 1ns/1ns
`default_nettype none
module data_tenure_delay_control_tb;
   import dtdc_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic addr_start = 1'b0, addr_wr = 1'b0, addr_burst = 1'b0, m_rd = 1'b0;
   logic [2:0] m_n = 3'h1, m_retry = 3'h0, m_err = 3'h0, wr_idx = 3'h0, good = 3'h0;
   logic [31:0] lfsr = 32'hf0aae125;
   logic [63:0] wr_data, rd_data, dbus_in, dbus_out;
   logic addr_ready, wr_data_take, rd_valid, rd_discard, tenure_done, error_exception;
   logic dbus_grant, beat_ack, beat_retry, error_ack, dbus_busy_out, dbus_busy_oe, dbus_oe;
   logic dbus_busy_in;
   logic [2:0] exp_q[$];
   int n_mismatch = 0, n_compared = 0, cyc = 0;
   function automatic logic [63:0] wword(input logic [2:0] k);
      return {32'h5a5a5a5a, 29'h0, k};
   endfunction
   assign wr_data = wword(wr_idx);
   assign dbus_busy_in = dbus_busy_oe; // only master on the busy wire
   dtdc_core u_dut (.clk_sys, .reset, .addr_start, .addr_wr, .addr_burst, .addr_ready,
      .wr_data, .wr_data_take, .rd_data, .rd_valid, .rd_discard, .tenure_done,
      .error_exception, .dbus_grant, .beat_ack, .beat_retry, .error_ack, .dbus_busy_in,
      .dbus_busy_out, .dbus_busy_oe, .dbus_in, .dbus_out, .dbus_oe);
   dtdc_slave_model u_slave (.clk_sys, .reset, .rnd(lfsr[7:0]), .m_rd, .m_n, .m_retry, .m_err,
      .dbus_busy_oe, .dbus_grant, .beat_ack, .beat_retry, .error_ack, .dbus_in);
   initial forever #50 clk_sys = ~clk_sys;
   // pacing bits change off the sampling edge
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(negedge clk_sys) lfsr <= lfsr_next(lfsr);
   always @(posedge clk_sys) if (wr_data_take === 1'b1) wr_idx <= wr_idx + 3'h1;
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   // issue one tenure, note its good beat count, wait for its end
   task automatic run(input logic wr, input logic bst, input logic [2:0] rt, input logic [2:0] er);
      @(negedge clk_sys);
      m_rd = !wr;
      m_n = bst ? 3'h4 : 3'h1;
      m_retry = rt;
      m_err = er;
      wr_idx = 3'h0;
      addr_wr = wr;
      addr_burst = bst;
      addr_start = 1'b1;
      exp_q.push_back(er != 3'h0 ? er - 3'h1 : m_n);
      @(negedge clk_sys);
      addr_start = 1'b0;
      while (tenure_done !== 1'b1) @(negedge clk_sys);
   endtask
   // two single reads back to back fill the pending queue, so a third must wait
   task automatic fill();
      @(negedge clk_sys);
      m_rd = 1'b1;
      m_n = 3'h1;
      m_retry = 3'h0;
      m_err = 3'h0;
      addr_wr = 1'b0;
      addr_burst = 1'b0;
      chk("addr_ready", 64'h1, {63'h0, addr_ready});
      addr_start = 1'b1;
      exp_q.push_back(3'h1);
      exp_q.push_back(3'h1);
      repeat (2) @(negedge clk_sys);
      addr_start = 1'b0;
      chk("addr_ready", 64'h0, {63'h0, addr_ready});
      chk("dbus_busy_out", 64'h0, {63'h0, dbus_busy_out});
      repeat (2) begin
         @(negedge clk_sys);
         while (tenure_done !== 1'b1) @(negedge clk_sys);
      end
   endtask
   // watcher: beats in order, counted per tenure, compared at its end
   always @(negedge clk_sys) if (!reset) begin
      if (rd_valid === 1'b1 && rd_discard !== 1'b1) begin
         chk("rd_data", {56'h0, 5'h14, good}, rd_data);
         good = good + 3'h1;
      end
      if (beat_ack === 1'b1 && dbus_oe === 1'b1) begin
         chk("dbus_out", wword(good), dbus_out);
         good = good + 3'h1;
      end
      if (tenure_done === 1'b1) begin
         chk("beats", {61'h0, exp_q.size() ? exp_q.pop_front() : 3'h7}, {61'h0, good});
         good = 3'h0;
      end
   end
   // hang guard: a few thousand cycles covers every tenure here
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (20) @(negedge clk_sys);
      reset = 1'b0;
      for (int r = 0; r < 3; r++) begin
         run(1'b0, 1'b0, 3'h0, 3'h0);
         run(1'b1, 1'b0, 3'h0, 3'h0);
         run(1'b0, 1'b1, 3'h0, 3'h0);
         run(1'b1, 1'b1, 3'h0, 3'h0);
         run(1'b0, 1'b1, 3'h3, 3'h0);
         run(1'b0, 1'b1, 3'h4, 3'h0);
         run(1'b0, 1'b0, 3'h1, 3'h0);
         run(1'b1, 1'b1, 3'h2, 3'h0);
      end
      fill();
      chk("error_exception", 64'h0, {63'h0, error_exception});
      run(1'b1, 1'b1, 3'h0, 3'h3);
      repeat (4) @(negedge clk_sys);
      chk("error_exception", 64'h1, {63'h0, error_exception});
      run(1'b0, 1'b1, 3'h0, 3'h0);
      // let the watcher finish the last tenure before the verdict
      repeat (2) @(negedge clk_sys);
      chk("notes_left", 64'h0, 64'(exp_q.size()));
      conclude();
   end
endmodule
`default_nettype wire
